/* File: core/msp_fifo.sv */
// Purpose: small synchronous frame queue
// Assumes: single clock, synchronous active-low reset
// Notes:   full and empty are exact; no write while full
`timescale 1ns/100ps
module msp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: core/msp_pkg.sv */
// Purpose: shared constants and types of the monitor serial command port
// Assumes: 10 MHz system clock, 24-bit frames
// Notes:   command addresses and field positions are fixed here only
package msp_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_BITS   = 8;
    localparam int DATA_BITS  = 16;
    localparam int TEMP_BITS  = 12;
    localparam int GPIO_BITS  = 12;
    localparam int REF_BITS   = 3;
    localparam int SW_BITS    = 5;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] MIN_EDGES = 5'h18;
    // timebase
    localparam int CLK_PERIOD_NS  = 100;
    localparam int CONV_DELAY_NS  = 20000;
    localparam int CONV_DELAY_CYC = (CONV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // command addresses (low seven bits of the command byte)
    localparam logic [6:0] ADDR_TEMP   = 7'h01;
    localparam logic [6:0] ADDR_TSCFG  = 7'h02;
    localparam logic [6:0] ADDR_REF    = 7'h03;
    localparam logic [6:0] ADDR_GPI    = 7'h04;
    localparam logic [6:0] ADDR_GPIOEN = 7'h05;
    localparam logic [6:0] ADDR_GPO    = 7'h06;
    localparam logic [6:0] ADDR_GENCFG = 7'h07;
    localparam int RW_BIT         = 7;
    localparam int TS_ONESHOT_BIT = 0;
    localparam int GEN_DRDY_BIT   = 0;
    // reset values
    localparam logic [23:0] RST_SHREG = 24'h000000;
    localparam logic [7:0]  RST_CMD   = 8'h00;
    localparam logic [15:0] RST_RESP  = 16'h0000;
    localparam logic [2:0]  RST_REF   = 3'h0;
    localparam logic [11:0] RST_GPIO  = 12'h000;
    localparam logic [11:0] RST_TEMP  = 12'h000;
    typedef enum logic [1:0] {
        TS_IDLE  = 2'b00,
        TS_CONV  = 2'b01,
        TS_SLEEP = 2'b10
    } msp_ts_t;
endpackage

/* File: core/msp_port.sv */
// Purpose: serial command port with temperature, reference and pin registers
// Assumes: sclk, chip select, din and pins are asynchronous; temp code is local
// Notes:   link sampled at 10 MHz, so sclk must stay well below 2.5 MHz
//
// What this block does
// - chip-select fall opens a new frame
// - sample din on falling sclk edges
// - launch dout on rising sclk edges
// - under 24 rising edges aborts the frame
// - longer frames decode the last 24 bits
// - dout floats when deselected, MSB at start
// - frame is command byte then data word
// - leading zero command bit means write
// - after a write, echo command then zeros
// - every frame echoes the previous command byte
// - read returns command then requested payload
// - decode only at chip-select rise
// - continuous mode converts regardless of bus
// - one-shot converts after temperature read instruction
// - one-shot read spans two frames
// - data-ready falls on result, released by deselect
// - no data-ready in continuous mode
// - results in two's complement code
// - reference mode decodes to five switches
// - sleep codes power down sensor and converters
// - input state register shows live pins
// - enable bit drives matching output value
// - result is 12-bit signed, sixteenth degrees
// - data-ready only when enabled in configuration
`timescale 1ns/100ps
module msp_port #(
    parameter int GPIO_W = 12
) (
    input  wire logic                            i_clk,
    input  wire logic                            i_resetn,
    input  wire logic                            i_sclk,
    input  wire logic                            i_chip_select_n,
    input  wire logic                            i_din,
    output logic                                 o_dout,
    output logic                                 o_dout_oe_n,
    output logic                                 o_data_ready_n,
    input  wire logic [msp_pkg::TEMP_BITS-1:0]   i_temp_code,
    output logic      [msp_pkg::SW_BITS-1:0]     o_ref_switch,
    output logic                                 o_deep_sleep,
    output logic                                 o_frame_drop,
    input  wire logic [GPIO_W-1:0]               i_gpio_in,
    output logic      [GPIO_W-1:0]               o_gpio_out,
    output logic      [GPIO_W-1:0]               o_gpio_oe_n
);
    import msp_pkg::*;

    localparam int CONV_B = CONV_DELAY_CYC + 2;
    // reference switch closes, bit 4 is switch A
    function automatic logic [SW_BITS-1:0] ref_decode(input logic [REF_BITS-1:0] m);
        case (m)
            3'h0:    ref_decode = 5'h11;
            3'h1:    ref_decode = 5'h03;
            3'h2:    ref_decode = 5'h18;
            3'h3:    ref_decode = 5'h0a;
            3'h5:    ref_decode = 5'h07;
            default: ref_decode = 5'h00;
        endcase
    endfunction

    function automatic logic is_sleep(input logic [REF_BITS-1:0] m);
        is_sleep = (m == 3'h4) | (m == 3'h6) | (m == 3'h7);
    endfunction

    logic                    sclk_m, sclk_s, sclk_d, sclk_rise, sclk_fall;
    logic                    cs_m, cs_s, cs_d, cs_fall, cs_rise, cs_act;
    logic                    din_m, din_s, seen_fall, dout_q, exec, ex_write;
    logic                    push, in_ready, out_valid, oneshot_start;
    logic                    ts_oneshot, drdy_en, conv_done, conv_cmd, drdy_q;
    logic [GPIO_W-1:0]       gpi_m, pin_input_state;
    logic [GPIO_W-1:0]       pin_output_enable, pin_output_value;
    logic [FRAME_BITS-1:0]   shreg, out_frame;
    logic [CMD_BITS-1:0]     prev_cmd, ex_cmd;
    logic [DATA_BITS-1:0]    resp_data, ex_data, next_resp;
    logic [4:0]              rise_cnt;
    logic [6:0]              ex_addr;
    logic [REF_BITS-1:0]     reference_mode_select;
    logic [TEMP_BITS-1:0]    temp_reg;
    msp_ts_t                 ts_state;
    logic [15:0]             conv_cnt;
    // two-stage synchronisers; edge detect compares the second stage with a third delay stage
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            cs_m   <= 1'b1;
            cs_s   <= 1'b1;
            cs_d   <= 1'b1;
            din_m  <= 1'b0;
            din_s  <= 1'b0;
        end else begin
            sclk_m <= i_sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            cs_m   <= i_chip_select_n;
            cs_s   <= cs_m;
            cs_d   <= cs_s;
            din_m  <= i_din;
            din_s  <= din_m;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            gpi_m           <= RST_GPIO;
            pin_input_state <= RST_GPIO;
        end else begin
            gpi_m           <= i_gpio_in;
            pin_input_state <= gpi_m;
        end
    end

    assign sclk_rise = ~sclk_d & sclk_s;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign cs_fall   = cs_d & ~cs_s;
    assign cs_rise   = ~cs_d & cs_s;
    assign cs_act    = ~cs_s;

    // shift register: echo loaded at frame start, din shifted at sclk fall
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            shreg <= RST_SHREG;
        end else if (cs_fall) begin
            shreg <= {prev_cmd, resp_data};
        end else if (cs_act && sclk_fall) begin
            shreg <= {shreg[FRAME_BITS-2:0], din_s};
        end
    end

    // rising-edge count only judges validity, never triggers decode
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rise_cnt  <= '0;
            seen_fall <= 1'b0;
        end else if (cs_fall) begin
            rise_cnt  <= '0;
            seen_fall <= 1'b0;
        end else if (cs_act) begin
            if (sclk_fall) begin
                seen_fall <= 1'b1;
            end
            if (sclk_rise && rise_cnt != MIN_EDGES) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end

    // launch on rising edge after first fall
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            dout_q <= 1'b0;
        end else if (cs_fall) begin
            dout_q <= prev_cmd[CMD_BITS-1];
        end else if (cs_act && sclk_rise && seen_fall) begin
            dout_q <= shreg[FRAME_BITS-1];
        end
    end

    assign o_dout = dout_q;
    assign o_dout_oe_n = cs_s;

    // short frames are dropped; decode at select rise
    assign push = cs_rise && (rise_cnt == MIN_EDGES);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_frame_drop <= 1'b0;
        end else begin
            o_frame_drop <= push & ~in_ready;
        end
    end

    // queue drained only between frames, so a frame never alters state mid-shift
    msp_fifo #(
        .WIDTH (FRAME_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_frames (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (push),
        .o_in_ready  (in_ready),
        .i_in_data   (shreg),
        .o_out_valid (out_valid),
        .i_out_ready (cs_s),
        .o_out_data  (out_frame)
    );

    assign exec     = out_valid & cs_s;
    assign ex_cmd   = out_frame[FRAME_BITS-1:DATA_BITS];
    assign ex_data  = out_frame[DATA_BITS-1:0];
    assign ex_addr  = ex_cmd[6:0];
    assign ex_write = ~ex_cmd[RW_BIT];

    assign oneshot_start = exec & ~ex_write & (ex_addr == ADDR_TEMP) & ts_oneshot;

    // register writes
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            reference_mode_select <= RST_REF;
            pin_output_enable     <= RST_GPIO;
            pin_output_value      <= RST_GPIO;
            ts_oneshot            <= 1'b0;
            drdy_en               <= 1'b0;
        end else if (exec && ex_write) begin
            case (ex_addr)
                ADDR_REF:    reference_mode_select <= ex_data[REF_BITS-1:0];
                ADDR_GPIOEN: pin_output_enable     <= ex_data[GPIO_W-1:0];
                ADDR_GPO:    pin_output_value      <= ex_data[GPIO_W-1:0];
                ADDR_TSCFG:  ts_oneshot            <= ex_data[TS_ONESHOT_BIT];
                ADDR_GENCFG: drdy_en               <= ex_data[GEN_DRDY_BIT];
                default:     ts_oneshot            <= ts_oneshot;
            endcase
        end
    end

    // payload selected for the next frame
    always_comb begin
        next_resp = '0;
        case (ex_addr)
            ADDR_TEMP:   next_resp = {{4{temp_reg[TEMP_BITS-1]}}, temp_reg};
            ADDR_TSCFG:  next_resp = {15'h0000, ts_oneshot};
            ADDR_REF:    next_resp = {13'h0000, reference_mode_select};
            ADDR_GPI:    next_resp = {4'h0, pin_input_state};
            ADDR_GPIOEN: next_resp = {4'h0, pin_output_enable};
            ADDR_GPO:    next_resp = {4'h0, pin_output_value};
            ADDR_GENCFG: next_resp = {15'h0000, drdy_en};
            default:     next_resp = '0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            prev_cmd  <= RST_CMD;
            resp_data <= RST_RESP;
        end else if (exec) begin
            prev_cmd <= ex_cmd;
            resp_data <= ex_write ? RST_RESP : next_resp;
        end else if (conv_done && prev_cmd == {1'b1, ADDR_TEMP}) begin
            // second frame carries the fresh result
            resp_data <= {{4{i_temp_code[TEMP_BITS-1]}}, i_temp_code};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_ref_switch <= '0;
            o_deep_sleep <= 1'b0;
        end else begin
            o_ref_switch <= ref_decode(reference_mode_select);
            o_deep_sleep <= is_sleep(reference_mode_select);
        end
    end

    assign o_gpio_out  = pin_output_value;
    assign o_gpio_oe_n = ~pin_output_enable;

    // temperature sensor timebase, one conversion per CONV_DELAY_CYC-cycle countdown of conv_cnt
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ts_state <= TS_IDLE;
            conv_cnt <= '0;
            conv_cmd <= 1'b0;
        end else begin
            case (ts_state)
                TS_IDLE: begin
                    if (is_sleep(reference_mode_select)) begin
                        ts_state <= TS_SLEEP;
                    end else if (!ts_oneshot || oneshot_start) begin
                        ts_state <= TS_CONV;
                        conv_cnt <= 16'(CONV_DELAY_CYC - 1);
                        conv_cmd <= oneshot_start;
                    end
                end
                TS_CONV: begin
                    if (is_sleep(reference_mode_select)) begin
                        ts_state <= TS_SLEEP;
                    end else if (oneshot_start) begin
                        conv_cnt <= 16'(CONV_DELAY_CYC - 1);
                        conv_cmd <= 1'b1;
                    end else if (conv_cnt == '0) begin
                        ts_state <= TS_IDLE;
                    end else begin
                        conv_cnt <= conv_cnt - 16'h0001;
                    end
                end
                TS_SLEEP: begin
                    if (!is_sleep(reference_mode_select)) begin
                        ts_state <= TS_IDLE;
                    end
                end
                default: ts_state <= TS_IDLE;
            endcase
        end
    end

    assign conv_done = (ts_state == TS_CONV) && (conv_cnt == '0)
                       && !is_sleep(reference_mode_select);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            temp_reg <= RST_TEMP;
        end else if (conv_done) begin
            temp_reg <= i_temp_code;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            drdy_q <= 1'b0;
        end else if (conv_done && conv_cmd && ts_oneshot && drdy_en) begin
            drdy_q <= 1'b1;
        end else if (cs_rise || !drdy_en || !ts_oneshot) begin
            drdy_q <= 1'b0;
        end
    end

    assign o_data_ready_n = ~drdy_q;

    // checks
    sequence s_frame_open;
        cs_fall;
    endsequence
    sequence s_short_close;
        cs_rise && (rise_cnt != MIN_EDGES);
    endsequence
    sequence s_oneshot_go;
        (ts_state == TS_IDLE) && oneshot_start && !is_sleep(reference_mode_select);
    endsequence
    a_dout_float: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cs_s |-> o_dout_oe_n)
        else $error("dout driven while deselected");
    a_echo_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_frame_open |=> (shreg[23:16] == $past(prev_cmd)) && (o_dout == shreg[23]))
        else $error("echo byte not loaded at frame start");
    a_sample_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (cs_act && sclk_fall && !cs_fall) |=> (shreg[0] == $past(din_s)))
        else $error("din not sampled on falling sclk");
    a_abort_short: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_short_close |-> !push)
        else $error("short frame was decoded");
    a_decode_last: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (cs_rise && rise_cnt == MIN_EDGES && in_ready && !out_valid)
        |=> out_valid && (out_frame == $past(shreg)))
        else $error("last 24 bits not queued");
    a_write_zeros: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (exec && ex_write) |=> (resp_data == 16'h0000) && (prev_cmd == $past(ex_cmd)))
        else $error("write did not clear echo payload");
    a_sleep_open: assert property (@(posedge i_clk) disable iff (!i_resetn)
        is_sleep(reference_mode_select) |=> (o_ref_switch == 5'h00) && o_deep_sleep)
        else $error("sleep code left switches closed");
    a_conv_delay: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_oneshot_go |=> (ts_state == TS_CONV) ##[1:CONV_B] conv_done)
        else $error("one-shot conversion not completed in time");
    a_ready_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (conv_done && conv_cmd && ts_oneshot && drdy_en) |=> !o_data_ready_n)
        else $error("data-ready did not fall on result");
    a_ready_cont: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!ts_oneshot && !drdy_q) |=> o_data_ready_n)
        else $error("data-ready signalled in continuous mode");
    a_gpo_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (exec && ex_write && ex_addr == ADDR_GPO) |=> (o_gpio_out == $past(ex_data[11:0])))
        else $error("output value not driven after write");
    a_cont_period: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (conv_done && !ts_oneshot && !is_sleep(reference_mode_select))
        |=> ##[1:CONV_B] (conv_done || ts_oneshot || is_sleep(reference_mode_select)))
        else $error("continuous conversion stalled");
endmodule

/* File: verification/msp_master.sv */
// Purpose: behavioural serial master facing the port
// Assumes: sclk idles high, 800 ns period
// Notes:   din shows the inverted last bit while deselected
`timescale 1ns/100ps
module msp_master (
    output logic        o_sclk,
    output logic        o_cs_n,
    output logic        o_din,
    input  wire logic   i_dout,
    output logic        o_done,
    output logic [31:0] o_rx
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
        o_done = 1'b0;
        o_rx   = 32'h0;
    end
    task automatic xfer(input logic [31:0] tx, input int n);
        o_cs_n = 1'b0;
        o_rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            o_din = tx[i];
            #400;
            o_sclk = 1'b0;
            #400;
            // dout settled long before the rise
            o_rx = {o_rx[30:0], i_dout};
            o_sclk = 1'b1;
        end
        #400;
        o_cs_n = 1'b1;
        o_din = ~o_din;
        o_done = 1'b1;
        #1000;
        o_done = 1'b0;
    endtask
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench of the serial command port
// Assumes: 10 MHz clock, inputs move on falling clock edges
// Notes:   answers are queued by the driver, checked by a monitor
`timescale 1ns/100ps
module tb;
    import msp_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        sclk, cs_n, din, dout, dout_oe_n, drdy_n, deep, done;
    logic [31:0] rx, exp_rx;
    logic [31:0] q[$];
    logic [11:0] temp = 12'hd80;
    logic [11:0] ext = 12'h000;
    logic [11:0] en, val, gpo, oe_n, pins;
    logic [4:0]  sw;
    logic [7:0]  pc = 8'h00;
    logic [4:0]  swt [8] = '{5'h11, 5'h03, 5'h18, 5'h0a, 5'h00, 5'h07, 5'h00, 5'h00};
    int          fails = 0, check_count = 0, seed = 32'hb026, k, w;

    // pin level seen by both sides of a two-way pin
    assign pins = (~oe_n & gpo) | (oe_n & ext);

    always #50 i_clk = ~i_clk;

    msp_port dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk),
        .i_chip_select_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(dout_oe_n),
        .o_data_ready_n(drdy_n), .i_temp_code(temp), .o_ref_switch(sw),
        .o_deep_sleep(deep), .o_frame_drop(), .i_gpio_in(pins), .o_gpio_out(gpo),
        .o_gpio_oe_n(oe_n));
    msp_master m (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
        .o_done(done), .o_rx(rx));

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // answer leads with the previous command; long frames pass bits on
    task automatic frm(input logic [31:0] tx, input int n, input logic [15:0] pay);
        q.push_back((n > 24) ? {pc, pay, tx[31:24]} : ({8'h00, pc, pay} >> (24 - n)));
        m.xfer(tx, n);
        if (n >= 24) begin
            pc = tx[23:16];
        end
    endtask

    always @(posedge done) begin
        exp_rx = q.pop_front();
        chk(rx, exp_rx);
    end

    initial begin
        #2000000;
        fails++;
        tally_and_finish;
    end

    initial begin
        repeat (16) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clk);
        // ends on code 000 so the sensor is awake again
        for (int i = 0; i < 8; i++) begin
            k = (i + 1) % 8;
            frm({8'h03, 13'h0, 3'(k)}, 24, 16'h0);
            chk(sw, swt[k]);
            chk(deep, k inside {4, 6, 7});
        end
        en = 12'($random(seed));
        val = 12'($random(seed));
        ext = 12'($random(seed));
        frm({8'h05, 4'h0, en}, 24, 16'h0);
        frm({8'h06, 4'h0, val}, 24, 16'h0);
        frm(32'h840000, 24, 16'h0);
        chk({oe_n, gpo}, {~en, val});
        chk(dout_oe_n, 1'b1);
        frm(32'h000000, 24, {4'h0, pins});
        frm({8'h03, 13'h0, 3'h5}, 23, 16'h0);
        chk(sw, 5'h11);
        frm({8'ha5, 8'h03, 13'h0, 3'h2}, 32, 16'h0);
        chk(sw, 5'h18);
        frm(32'h030000, 24, 16'h0);
        // continuous read returns the stored minus 40 degree code
        frm(32'h810000, 24, 16'h0);
        frm(32'h070001, 24, 16'hfd80);
        repeat (250) @(negedge i_clk);
        chk(drdy_n, 1'b1);
        frm(32'h020001, 24, 16'h0);
        repeat (250) @(negedge i_clk);
        chk(drdy_n, 1'b1);
        // new code for the one-shot, so a stale result would show
        temp = 12'h190;
        frm(32'h810000, 24, 16'h0);
        for (w = 0; w < 400 && drdy_n !== 1'b0; w++) @(negedge i_clk);
        chk(drdy_n, 1'b0);
        frm(32'h000000, 24, 16'h0190);
        chk(drdy_n, 1'b1);
        tally_and_finish;
    end
endmodule
